// File: rtl/touch_adc_conversion_control.sv
// Purpose: sequences touch and auxiliary conversions: reference power-up, settling, precharge, sense, averaging
// Assumes: the analog converter answers each sample request with a done pulse and raw data
// Notes:
// Notes on behaviour
// R1 - result resolution is 8, 10 or 12 bits, chosen by a setting
// R2 - conversion clock selectable at 8, 4, 2 or 1 MHz; the code gives 10, 5, 2 or 1 MHz from the 10 MHz core clock
// R3 - at 8 MHz only 8-bit resolution is allowed
// R4 - at 4 MHz 12-bit is refused; 12-bit needs 1 or 2 MHz
// R5 - wait programmable panel settling time after drivers switch on
// R6 - touch detect precharges, then senses, each for a programmable time
// R7 - average none, 4, 8 or 16 readings into one result
// R8 - all settings govern every conversion kind, not only touch
// R9 - touch position is ratiometric; other conversions use selected reference
// R10 - internal reference selectable between 1.2 V and 2.5 V
// R11 - internal reference powered down while no conversion runs
// R12 - always-on setting keeps the reference powered
// R13 - reference power-up delay before each conversion needing it
// R14 - external reference may replace the internal one for non-touch conversions
// R15 - delay and settling precede sampling; result only after all readings
//
// Implementation choices: the strobed register port and the register addresses.
`include "adc_ctrl_regs.svh"
module touch_adc_conversion_control
	import adc_ctrl_pkg::*;
#(
	parameter int DATA_W = 12
)
(
	input  wire logic                 core_clk_in,
	input  wire logic                 rstn_in,
	input  wire logic [`ADDR_W-1:0]   addr_in,
	input  wire logic [15:0]          wdata_in,
	input  wire logic                 wr_in,
	input  wire logic                 rd_in,
	output logic      [15:0]          rdata_out,
	input  wire logic                 adc_done_in,
	input  wire logic [DATA_W-1:0]    adc_data_in,
	input  wire logic                 touched_in,
	output logic                      adc_sample_out,
	output logic                      adc_clk_en_out,
	output logic      [1:0]           adc_res_out,
	output logic      [2:0]           adc_chan_out,
	output logic                      drivers_on_out,
	output logic                      precharge_out,
	output logic                      sense_out,
	output logic                      ratiometric_out,
	output logic                      ref_power_out,
	output logic                      ref_2v5_out,
	output logic                      ref_ext_out,
	output logic                      busy_out
);
	// the trim to 8 and 10 bits assumes a 12-bit raw sample
	if (DATA_W != 12)
	begin : g_width_check
		$error("DATA_W must be 12");
	end

	typedef enum logic [2:0] {S_IDLE, S_REFUP, S_SETTLE, S_PRE, S_SENSE, S_SAMPLE, S_WAIT, S_DONE} seq_type;

	logic [1:0]        rst_sync_ff;
	logic              rst_n;
	logic [15:0]       cfg_ff;
	logic [15:0]       tim0_ff;
	logic [15:0]       tim1_ff;
	logic [3:0]        cmd_ff;
	seq_type           state_ff;
	logic [15:0]       cnt_ff;
	logic [4:0]        left_ff;
	logic [DATA_W+3:0] acc_ff;
	logic [DATA_W-1:0] result_ff;
	logic              valid_ff;
	logic              untouched_ff;
	logic              cfg_err_ff;
	logic [1:0]        adc_done_sync_ff;
	logic [1:0]        touched_sync_ff;
	logic              tick;
	logic              start;
	logic              is_touch;
	logic              need_ref;

	res_type    res;
	ckrate_type ckr;
	avg_type    avg;

	assign rst_n    = rst_sync_ff[1];
	assign res      = res_type'(cfg_ff[`CFG_RES_LSB +: 2]);
	assign ckr      = ckrate_type'(cfg_ff[`CFG_CLK_LSB +: 2]);
	assign avg      = avg_type'(cfg_ff[`CFG_AVG_LSB +: 2]);
	assign is_touch = cmd_ff[`CMD_TOUCH_BIT];
	assign need_ref = !is_touch && !cfg_ff[`CFG_EXT_REF_BIT] && !cfg_ff[`CFG_REF_ON_BIT];
	assign start    = wr_in && (addr_in == `REG_CMD) && (state_ff == S_IDLE);

	// microsecond count to core cycles
	function automatic logic [15:0] us_cycles(input logic [7:0] us);
		us_cycles = 16'(us) * 16'(`CYC_PER_US);
	endfunction

	function automatic logic [4:0] avg_count(input avg_type a);
		case (a)
			AVG_4:   avg_count = 5'd4;
			AVG_8:   avg_count = 5'd8;
			AVG_16:  avg_count = 5'd16;
			default: avg_count = 5'd1;
		endcase
	endfunction

	// resolution and clock pairing check
	function automatic logic pair_ok(input res_type r, input ckrate_type c);
		case (r)
			RES_8:   pair_ok = 1'b1;
			RES_10:  pair_ok = (c != CK_8M); // R3
			RES_12:  pair_ok = (c == CK_2M) || (c == CK_1M); // R4
			default: pair_ok = 1'b0;
		endcase
	endfunction

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	conv_clk_div u_div
	(
		.clk_in   (core_clk_in),
		.rst_n_in (rst_n),
		.rate_in  (ckr), // R2
		.tick_out (tick)
	);

	// adc done and the touch level come from the analog side, so both are resynchronised
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			{touched_sync_ff, adc_done_sync_ff} <= 4'h0;
		else
			{touched_sync_ff, adc_done_sync_ff} <= {touched_sync_ff[0], touched_in, adc_done_sync_ff[0], adc_done_in};
	end

	// configuration writes; an illegal resolution and clock pairing is refused and flagged
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_ff     <= `CFG_RESET;
			tim0_ff    <= `TIM_RESET;
			tim1_ff    <= `TIM_RESET;
			cfg_err_ff <= 1'b0;
		end
		else if (wr_in && state_ff == S_IDLE)
		begin
			case (addr_in)
				`REG_CFG:
				begin
					if (pair_ok(res_type'(wdata_in[`CFG_RES_LSB +: 2]),
					            ckrate_type'(wdata_in[`CFG_CLK_LSB +: 2]))) // R1 R3 R4
					begin
						cfg_ff     <= wdata_in & 16'h01ff;
						cfg_err_ff <= 1'b0;
					end
					else
						cfg_err_ff <= 1'b1;
				end
				`REG_TIMING0: tim0_ff <= wdata_in;
				`REG_TIMING1: tim1_ff <= wdata_in;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			cmd_ff <= 4'h0;
		else if (start)
			cmd_ff <= wdata_in[3:0];
	end

	// sequencer: one setting set governs every conversion kind
	always_ff @(posedge core_clk_in or negedge rst_n) // R8
	begin
		if (!rst_n)
		begin
			state_ff     <= S_IDLE;
			cnt_ff       <= 16'h0;
			left_ff      <= 5'd0;
			acc_ff       <= '0;
			untouched_ff <= 1'b0;
		end
		else
		begin
			case (state_ff)
				S_IDLE:
				begin
					if (start)
					begin
						state_ff <= S_REFUP;
						cnt_ff   <= 16'h0;
						acc_ff   <= '0;
						left_ff  <= avg_count(avg); // R7
					end
				end
				S_REFUP:
				begin
					cnt_ff <= cnt_ff + 16'h1;
					if (!need_ref || cnt_ff + 16'h1 >= us_cycles(tim0_ff[`TIM_REFUP_LSB +: 8])) // R13 R15
					begin
						state_ff <= S_SETTLE;
						cnt_ff   <= 16'h0;
					end
				end
				S_SETTLE:
				begin
					cnt_ff <= cnt_ff + 16'h1;
					if (cnt_ff + 16'h1 >= us_cycles(tim0_ff[`TIM_STAB_LSB +: 8])) // R5 R15
					begin
						state_ff <= is_touch ? S_PRE : S_SAMPLE;
						cnt_ff   <= 16'h0;
					end
				end
				S_PRE:
				begin
					cnt_ff <= cnt_ff + 16'h1;
					if (cnt_ff + 16'h1 >= us_cycles(tim1_ff[`TIM_PRE_LSB +: 8])) // R6
					begin
						state_ff <= S_SENSE;
						cnt_ff   <= 16'h0;
					end
				end
				S_SENSE:
				begin
					cnt_ff <= cnt_ff + 16'h1;
					if (cnt_ff + 16'h1 >= us_cycles(tim1_ff[`TIM_SENSE_LSB +: 8])) // R6
					begin
						cnt_ff <= 16'h0;
						if (touched_sync_ff[1])
							state_ff <= S_SAMPLE;
						else
						begin
							untouched_ff <= 1'b1;
							state_ff     <= S_DONE;
						end
					end
				end
				S_SAMPLE:
				begin
					untouched_ff <= 1'b0;
					if (tick)
						state_ff <= S_WAIT;
				end
				S_WAIT:
				begin
					if (adc_done_sync_ff[1])
					begin
						acc_ff  <= acc_ff + (DATA_W+4)'(adc_data_in);
						left_ff <= left_ff - 5'd1;
						state_ff <= (left_ff == 5'd1) ? S_DONE : S_SAMPLE; // R7 R15
					end
				end
				S_DONE:
					state_ff <= S_IDLE;
				default:
					state_ff <= S_IDLE;
			endcase
		end
	end

	// average and trim to the chosen resolution; the low bits are dropped, not rounded
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result_ff <= '0;
			valid_ff  <= 1'b0;
		end
		else if (state_ff == S_DONE && !untouched_ff)
		begin
			valid_ff <= 1'b1;
			case (res) // R1
				RES_8:   result_ff <= avg_div(acc_ff, avg) >> 4;
				RES_10:  result_ff <= avg_div(acc_ff, avg) >> 2;
				default: result_ff <= avg_div(acc_ff, avg);
			endcase
		end
		else if (rd_in && addr_in == `REG_RESULT)
			valid_ff <= 1'b0;
	end

	function automatic logic [DATA_W-1:0] avg_div(input logic [DATA_W+3:0] a, input avg_type g);
		case (g)
			AVG_4:   avg_div = a[DATA_W+1:2];
			AVG_8:   avg_div = a[DATA_W+2:3];
			AVG_16:  avg_div = a[DATA_W+3:4];
			default: avg_div = a[DATA_W-1:0];
		endcase
	endfunction

	// analog side controls, all registered
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			adc_sample_out  <= 1'b0;
			adc_clk_en_out  <= 1'b0;
			adc_res_out     <= 2'b00;
			adc_chan_out    <= 3'h0;
			drivers_on_out  <= 1'b0;
			precharge_out   <= 1'b0;
			sense_out       <= 1'b0;
			ratiometric_out <= 1'b0;
			ref_power_out   <= 1'b0;
			ref_2v5_out     <= 1'b0;
			ref_ext_out     <= 1'b0;
			busy_out        <= 1'b0;
		end
		else
		begin
			adc_sample_out  <= (state_ff == S_SAMPLE) && tick;
			adc_clk_en_out  <= tick;
			adc_res_out     <= cfg_ff[`CFG_RES_LSB +: 2];
			adc_chan_out    <= cmd_ff[`CMD_CHAN_LSB +: 3];
			drivers_on_out  <= (state_ff != S_IDLE) && (state_ff != S_REFUP) && (state_ff != S_DONE);
			precharge_out   <= (state_ff == S_PRE); // R6
			sense_out       <= (state_ff == S_SENSE); // R6
			ratiometric_out <= is_touch; // R9
			ref_power_out   <= cfg_ff[`CFG_REF_ON_BIT] || (!is_touch && state_ff != S_IDLE); // R11 R12
			ref_2v5_out     <= cfg_ff[`CFG_VREF_HI_BIT]; // R10
			ref_ext_out     <= cfg_ff[`CFG_EXT_REF_BIT] && !is_touch; // R14
			busy_out        <= (state_ff != S_IDLE) || start;
		end
	end

	// read port, data one cycle after the strobe
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			rdata_out <= 16'h0;
		else if (rd_in)
		begin
			case (addr_in)
				`REG_CFG:     rdata_out <= cfg_ff;
				`REG_TIMING0: rdata_out <= tim0_ff;
				`REG_TIMING1: rdata_out <= tim1_ff;
				`REG_CMD:     rdata_out <= {12'h0, cmd_ff};
				`REG_STATUS:  rdata_out <= {12'h0, cfg_err_ff, untouched_ff, valid_ff, state_ff != S_IDLE};
				`REG_RESULT:  rdata_out <= {4'h0, result_ff};
				default:      rdata_out <= 16'h0;
			endcase
		end
		else
			rdata_out <= 16'h0;
	end
endmodule // touch_adc_conversion_control

// File: rtl/adc_ctrl_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts of the conversion control
// Assumes: 10 MHz core clock, word-indexed register port
// Notes: times are given in microseconds; cycle counts are derived from the clock rate
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define CLK_MHZ            10
`define ADDR_W             4
`define REG_CFG            4'h0
`define REG_TIMING0        4'h1
`define REG_TIMING1        4'h2
`define REG_CMD            4'h3
`define REG_STATUS         4'h4
`define REG_RESULT         4'h5

// configuration register fields
`define CFG_RES_LSB        0
`define CFG_CLK_LSB        2
`define CFG_AVG_LSB        4
`define CFG_VREF_HI_BIT    6
`define CFG_REF_ON_BIT     7
`define CFG_EXT_REF_BIT    8
`define CFG_RESET          16'h0000

// timing fields, each in microseconds, 8 bits wide
`define TIM_STAB_LSB       0
`define TIM_REFUP_LSB      8
`define TIM_PRE_LSB        0
`define TIM_SENSE_LSB      8
`define TIM_RESET          16'h0101

// cycles per microsecond, at least one
`define CYC_PER_US         ((`CLK_MHZ < 1) ? 1 : `CLK_MHZ)

// command field
`define CMD_CHAN_LSB       0
`define CMD_TOUCH_BIT      3

`endif

// File: rtl/adc_ctrl_pkg.sv
// Purpose: types shared by the conversion control files
// Assumes: nothing beyond the header
// Notes: none
package adc_ctrl_pkg;
	typedef enum logic [1:0] {RES_8, RES_10, RES_12, RES_RSVD} res_type;
	typedef enum logic [1:0] {CK_8M, CK_4M, CK_2M, CK_1M} ckrate_type;
	typedef enum logic [1:0] {AVG_1, AVG_4, AVG_8, AVG_16} avg_type;
	typedef enum logic [2:0] {CH_TOUCH_X, CH_TOUCH_Y, CH_TOUCH_Z, CH_BAT1, CH_BAT2, CH_AUX1, CH_AUX2, CH_TEMP}
		chan_type;
endpackage

// File: rtl/conv_clk_div.sv
// Purpose: divides the core clock into conversion clock enable pulses
// Assumes: core clock at 10 MHz; rates are approximated by whole-cycle periods
// Notes: 8 MHz cannot be reached from 10 MHz, so it becomes one pulse every cycle
`include "adc_ctrl_regs.svh"
module conv_clk_div
	import adc_ctrl_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire ckrate_type rate_in,
	output logic            tick_out
);
	logic [3:0] cnt_ff;
	logic [3:0] top;

	always_comb
	begin
		case (rate_in)
			CK_8M:   top = 4'h0;
			CK_4M:   top = 4'h1;
			CK_2M:   top = 4'h4;
			CK_1M:   top = 4'h9;
			default: top = 4'h9;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_ff   <= 4'h0;
			tick_out <= 1'b0;
		end
		else if (cnt_ff >= top)
		begin
			cnt_ff   <= 4'h0;
			tick_out <= 1'b1;
		end
		else
		begin
			cnt_ff   <= cnt_ff + 4'h1;
			tick_out <= 1'b0;
		end
	end
endmodule // conv_clk_div

// File: testbench/conv_ctrl_chk_assertions.sv
// Purpose: port checks of the conversion control
// Assumes: one clock domain, reset active low
// Notes: the sample counter is helper logic
module conv_ctrl_chk
(
	input wire logic        core_clk_in,
	input wire logic        rstn_in,
	input wire logic        rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic        adc_sample_out,
	input wire logic        adc_clk_en_out,
	input wire logic [1:0]  adc_res_out,
	input wire logic        precharge_out,
	input wire logic        sense_out,
	input wire logic        ratiometric_out,
	input wire logic        ref_power_out,
	input wire logic        ref_ext_out,
	input wire logic        busy_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	logic [4:0] cnt_ff;
	always_ff @(posedge core_clk_in or negedge rstn_in)
		if (!rstn_in)
			cnt_ff <= 5'h00;
		else if (!busy_out)
			cnt_ff <= 5'h00;
		else if (adc_sample_out)
			cnt_ff <= cnt_ff + 5'h01;
	a_count_legal: assert property ($fell(busy_out) |-> cnt_ff inside {5'h00, 5'h01, 5'h04, 5'h08, 5'h10})
		else $error("reading count per result wrong");
	a_fast_8bit: assert property (busy_out && $past(busy_out, 2) && adc_clk_en_out && $past(adc_clk_en_out)
		|-> adc_res_out == 2'h0) else $error("fast clock with wide result");
	a_mid_no12: assert property (busy_out && $past(busy_out, 3) && adc_clk_en_out && $past(adc_clk_en_out, 2)
		|-> adc_res_out != 2'h2) else $error("12 bit at 4 MHz or faster");
	a_pre_sense_excl: assert property (precharge_out |-> !sense_out)
		else $error("precharge and sense together");
	a_sense_after_pre: assert property ($rose(sense_out) |-> $past(precharge_out))
		else $error("sense without precharge");
	a_sample_busy: assert property (adc_sample_out |-> busy_out && !precharge_out && !sense_out)
		else $error("sample outside its phase");
	a_ref_ready: assert property (adc_sample_out && !ratiometric_out |-> ref_power_out || ref_ext_out)
		else $error("sample with reference off");
	a_read_zero: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
		else $error("read data outside its cycle");
	a_reset_quiet: assert property ($rose(rstn_in) |-> !busy_out ##1 !busy_out)
		else $error("busy right after reset");
	c_touch: cover property (adc_sample_out && ratiometric_out);
	c_avg16: cover property ($fell(busy_out) && cnt_ff == 5'h10);
	c_start: cover property ($rose(busy_out));
endmodule // conv_ctrl_chk

bind touch_adc_conversion_control conv_ctrl_chk u_conv_ctrl_chk (.core_clk_in, .rstn_in, .rd_in, .rdata_out,
	.adc_sample_out, .adc_clk_en_out, .adc_res_out, .precharge_out, .sense_out, .ratiometric_out,
	.ref_power_out, .ref_ext_out, .busy_out);

// File: testbench/adc_panel_model.sv
// Purpose: behavioural converter and touch panel
// Assumes: one done pulse per sample request
// Notes: readings alternate base and base plus 2
module adc_panel_model
(
	input wire logic         clk_in,
	input wire logic         sample_in,
	input wire logic         sense_in,
	input wire logic         touch_in,
	input wire logic         clr_in,
	input wire logic [7:0]   wait_in,
	input wire logic [11:0]  base_in,
	output logic             done_out = 1'b0,
	output logic [11:0]      data_out = 12'h000,
	output logic             touched_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_ff = 8'h00;
	logic       odd_ff = 1'b0;
	// unsensed panel gives no valid level
	assign touched_out = sense_in ? touch_in : ~touch_in;
	always @(posedge clk_in)
	begin
		done_out <= 1'b0;
		if (clr_in)
			odd_ff <= 1'b0;
		if (sample_in)
		begin
			cnt_ff <= wait_in;
			data_out <= ~data_out;
		end
		else if (cnt_ff != 8'h00)
		begin
			cnt_ff <= cnt_ff - 8'h01;
			if (cnt_ff == 8'h01)
			begin
				done_out <= 1'b1;
				data_out <= base_in + (odd_ff ? 12'h002 : 12'h000);
				odd_ff <= ~odd_ff;
			end
		end
	end
endmodule // adc_panel_model

// File: testbench/touch_adc_conversion_control_tb.sv
// Purpose: self-checking bench of the conversion control
// Assumes: timing fields set to a few microseconds
// Notes: the panel model answers every sample
`include "adc_ctrl_regs.svh"
module touch_adc_conversion_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        touch = 1'b0;
	logic        clr = 1'b0;
	logic [7:0]  wt = 8'h01;
	logic [15:0] rdata, v;
	logic [11:0] data;
	logic        done, tchd, smp, pre, sen, rat, rp, r25, rext, busy, ratv, extv, v25;
	logic [1:0]  res_o, resv;
	logic [2:0]  chan_o, chv;
	logic        drv_o, drv;
	int          bad_count = 0, samples_checked = 0, n, first, np, ns;
	logic [16:0] rows [8] = '{17'h00000, 17'h10001, 17'h10002, 17'h00005, 17'h10006, 17'h0000a, 17'h0000e,
		17'h001fd};
	logic [15:0] last = 16'h0000;
	touch_adc_conversion_control u_touch_adc_conversion_control (.core_clk_in(clk), .rstn_in(rstn),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata), .adc_done_in(done),
		.adc_data_in(data), .touched_in(tchd), .adc_sample_out(smp), .adc_clk_en_out(), .adc_res_out(res_o),
		.adc_chan_out(chan_o), .drivers_on_out(drv_o), .precharge_out(pre), .sense_out(sen), .ratiometric_out(rat),
		.ref_power_out(rp), .ref_2v5_out(r25), .ref_ext_out(rext), .busy_out(busy));
	adc_panel_model u_adc_panel_model (.clk_in(clk), .sample_in(smp), .sense_in(sen), .touch_in(touch),
		.clr_in(clr), .wait_in(wt), .base_in(12'h123), .done_out(done), .data_out(data), .touched_out(tchd));
	initial
		forever #50 clk = ~clk;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask
	// counts samples and phase lengths until the block goes idle
	task automatic watch;
		int k;
		k = 0;
		n = 0;
		first = 0;
		np = 0;
		ns = 0;
		clr <= 1'b0;
		while (k < 3000 && (k < 4 || busy !== 1'b0))
		begin
			@(posedge clk);
			#1;
			k++;
			np += pre;
			ns += sen;
			if (smp === 1'b1)
			begin
				n++;
				first = (first == 0) ? k : first;
				ratv = rat;
				extv = rext;
				v25 = r25;
				resv = res_o;
				chv = chan_o;
				drv = drv_o;
			end
		end
		if (k >= 3000)
			bad_count++;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic run(input logic [15:0] c);
		clr <= 1'b1;
		wr(`REG_CMD, c);
		watch();
	endtask
	task automatic res_chk(input logic [11:0] e);
		rd(`REG_STATUS, v);
		chk({15'h0, v[1]}, 16'h0001, "valid");
		rd(`REG_RESULT, v);
		chk(v, {4'h0, e}, "result");
	endtask
	initial
	begin
		#2000000;
		bad_count++;
		wrap_up();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		wr(`REG_TIMING0, 16'h1402);
		wr(`REG_TIMING1, 16'h0304);
		foreach (rows[i])
		begin
			wr(`REG_CFG, rows[i][15:0]);
			last = rows[i][16] ? last : rows[i][15:0];
			rd(`REG_CFG, v);
			chk(v, last, "cfg");
			rd(`REG_STATUS, v);
			chk({15'h0, v[3]}, {15'h0, rows[i][16]}, "cfg_err");
		end
		wr(`REG_CFG, 16'h005a);
		wt <= 8'd40;
		run(16'h0005);
		chk(16'(n), 16'd4, "avg4");
		chk({15'h0, first >= 215}, 16'h0001, "refup");
		chk({13'h0, ratv, v25, extv}, 16'h0002, "ref_sel");
		chk({10'h0, drv, resv, chv}, {10'h0, 1'b1, 2'h2, 3'h5}, "drv_res_chan");
		res_chk(12'h124);
		chk({15'h0, rp}, 16'h0000, "ref_idle");
		wr(`REG_CFG, 16'h008a);
		wt <= 8'd1;
		run(16'h0003);
		chk({15'h0, first < 215}, 16'h0001, "ref_on");
		chk({15'h0, first >= 22}, 16'h0001, "settle");
		chk({15'h0, rp}, 16'h0001, "ref_kept");
		res_chk(12'h123);
		wr(`REG_CFG, 16'h010a);
		run(16'h0006);
		chk({15'h0, extv}, 16'h0001, "ext_ref");
		wr(`REG_CFG, 16'h0005);
		run(16'h0001);
		res_chk(12'h048);
		wr(`REG_CFG, 16'h0000);
		run(16'h0002);
		res_chk(12'h012);
		wr(`REG_CFG, 16'h003e);
		touch <= 1'b1;
		run(16'h0008);
		chk(16'(n), 16'd16, "avg16");
		chk({15'h0, ratv}, 16'h0001, "ratio");
		chk({15'h0, np >= 40 && np <= 42}, 16'h0001, "precharge");
		chk({15'h0, ns >= 30 && ns <= 32}, 16'h0001, "sense");
		res_chk(12'h124);
		touch <= 1'b0;
		run(16'h0009);
		chk(16'(n), 16'd0, "untouched");
		rd(`REG_STATUS, v);
		chk({15'h0, v[2]}, 16'h0001, "no_touch");
		wr(`REG_CMD, 16'h0005);
		wr(`REG_CFG, 16'h0000);
		watch();
		rd(`REG_CFG, v);
		chk(v, 16'h003e, "busy_write");
		wr(`REG_CMD, 16'h0005);
		repeat (5) @(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		#1;
		chk({14'h0, busy, rp}, 16'h0000, "in_reset");
		@(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`REG_TIMING0, v);
		chk(v, `TIM_RESET, "tim_reset");
		wrap_up();
	end
endmodule // touch_adc_conversion_control_tb
